// *** logic/mcr_defs.vh ***
`ifndef MCR_DEFS_VH
`define MCR_DEFS_VH
// ==============================================
// register locations
`define MCR_ADDR_ENGINE      16'h2106
`define MCR_ADDR_PROG_BASE   16'h2109
`define MCR_ADDR_CLK_DIV     16'h2200
`define MCR_ADDR_IDENT_HIGH  16'h2300
`define MCR_ADDR_IDENT_LOW   16'h2301
`define MCR_ADDR_ANALOG      16'h2704
`define MCR_ADDR_BATT_LEVEL  16'h2885
// ==============================================
// field positions
`define MCR_BIT_ENGINE_RUN   0
`define MCR_BIT_CHOP_LO      2
`define MCR_BIT_CHOP_HI      3
`define MCR_BIT_CLK_DIV      5
`define MCR_BIT_BATT_LOAD    3
`define MCR_BIT_REF_EN       4
// ==============================================
// reset and wake values
`define MCR_RST_ENGINE_RUN   1'h0
`define MCR_RST_CHOP         2'h0
`define MCR_RST_PROG_BASE    6'h1f
`define MCR_RST_CLK_DIV      1'h0
`define MCR_RST_BATT_LOAD    1'h0
`define MCR_RST_REF_EN       1'h0
// ==============================================
// chop selector codes and clock figures
`define MCR_CHOP_TOGGLE_A    2'h0
`define MCR_CHOP_POSITIVE    2'h1
`define MCR_CHOP_REVERSED    2'h2
`define MCR_CHOP_TOGGLE_B    2'h3
`define MCR_DIV_SLOW_SHIFT   3
`define MCR_DIV_FAST_SHIFT   2
`define MCR_PROG_BASE_SHIFT  10
`define MCR_MCLK_SLOW_HZ     6291456
`define MCR_MCLK_FAST_HZ     19660800
`endif

// *** logic/mcr_clock_divider.v ***
`timescale 1ns/10ps
`include "mcr_defs.vh"
module mcr_clock_divider (
	input  wire mclk_i,
	input  wire reset_i,
	input  wire div_eight_i,
	output reg  conv_clk_o
);
	// ==============================================
	// divide by four or eight; the choice is checked every cycle, so it acts on the half period in progress
	reg [2:0] count;
	wire      half_tick;

	assign half_tick = div_eight_i ? (count[1:0] == 2'h3) : (count[0] == 1'h1);

	always @(posedge mclk_i) begin
		if (reset_i) begin
			count      <= 3'h0;
			conv_clk_o <= 1'h0;
		end else if (half_tick) begin
			count      <= 3'h0;
			conv_clk_o <= ~conv_clk_o;
		end else begin
			count <= count + 3'h1;
		end
	end
endmodule

// *** logic/mcr_config_regs.v ***
`timescale 1ns/10ps
`include "mcr_defs.vh"
// Behaviour
// - bits that are write-only read back as zero.
// - writable bits take their listed value on reset and on wake, read-only bits are left alone.
// - writable bits are stored from processor writes and readable bits are returned at their location.
// - the reference enable at 0x2704 bit 4 resets to 0 and when clear disables converter and reference.
// - the clock divide bit at 0x2200 bit 5 selects master clock over four (0) or over eight (1).
// - the master clock is 6.291456 or 19.660800 MHz by the fast select, and the converter clock follows the divider.
// - the battery load bit at 0x2704 bit 3 connects a 100 uA test load and resets to 0.
// - the battery level byte at 0x2885 is read-only, holds the measurement and is never initialised.
// - the program base at 0x2109 resets to 31 and the engine fetches from 1024 times it.
// - the identification reads as upper byte at 0x2300 and lower byte at 0x2301.
// - the chop state updates on each frame sync rising edge: 00 and 11 toggle, 01 positive, 10 reversed.
// - in toggle settings the chop state holds on the edge that ends an accumulation interval.
module mcr_config_regs #(
	parameter [15:0] IDENT_CODE = 16'h5a3c // arbitrary value
) (
	input  wire        mclk_i,
	input  wire        reset_i,
	input  wire        wake_i,
	input  wire        fast_pll_select_i,
	input  wire [15:0] addr_i,
	input  wire        wr_i,
	input  wire        rd_i,
	input  wire [7:0]  wdata_i,
	output reg  [7:0]  rdata_o,
	input  wire [7:0]  battery_level_i,
	input  wire        mux_frame_sync_i,
	input  wire        accum_end_i,
	output reg         converter_reference_enable_o,
	output reg         battery_load_enable_o,
	output reg         engine_run_o,
	output reg  [15:0] engine_program_start_o,
	output reg         chop_state_o,
	output reg         converter_clock_o,
	output reg         fast_master_clock_o
);
	// ==============================================
	// configuration storage
	reg       engine_run_enable;
	reg [1:0] reference_chop_select;
	reg [5:0] engine_program_base;
	reg       converter_clock_divide;
	reg       battery_load_enable;
	reg       converter_reference_enable;
	reg       chop_state;
	reg [2:0] sync_pipe;
	reg [7:0] next_rdata;
	wire      conv_clk;
	wire      frame_rise;

	function [15:0] prog_start;
		input [5:0] base;
		begin
			prog_start = {base, 10'h000};
		end
	endfunction

	always @(posedge mclk_i) begin
		if (reset_i || wake_i) begin
			engine_run_enable          <= `MCR_RST_ENGINE_RUN;
			reference_chop_select      <= `MCR_RST_CHOP;
			engine_program_base        <= `MCR_RST_PROG_BASE;
			converter_clock_divide     <= `MCR_RST_CLK_DIV;
			battery_load_enable        <= `MCR_RST_BATT_LOAD;
			converter_reference_enable <= `MCR_RST_REF_EN;
		end else if (wr_i) begin
			case (addr_i)
				`MCR_ADDR_ENGINE: begin
					engine_run_enable     <= wdata_i[`MCR_BIT_ENGINE_RUN];
					reference_chop_select <= wdata_i[`MCR_BIT_CHOP_HI:`MCR_BIT_CHOP_LO];
				end
				`MCR_ADDR_PROG_BASE: begin
					engine_program_base <= wdata_i[5:0];
				end
				`MCR_ADDR_CLK_DIV: begin
					converter_clock_divide <= wdata_i[`MCR_BIT_CLK_DIV];
				end
				`MCR_ADDR_ANALOG: begin
					battery_load_enable        <= wdata_i[`MCR_BIT_BATT_LOAD];
					converter_reference_enable <= wdata_i[`MCR_BIT_REF_EN];
				end
				default: begin
				end
			endcase
		end
	end

	// ==============================================
	// read path; unmapped and write-only locations read zero
	always @* begin
		next_rdata = 8'h00;
		case (addr_i)
			`MCR_ADDR_ENGINE: begin
				next_rdata[`MCR_BIT_ENGINE_RUN]               = engine_run_enable;
				next_rdata[`MCR_BIT_CHOP_HI:`MCR_BIT_CHOP_LO] = reference_chop_select;
			end
			`MCR_ADDR_PROG_BASE: begin
				next_rdata[5:0] = engine_program_base;
			end
			`MCR_ADDR_CLK_DIV: begin
				next_rdata[`MCR_BIT_CLK_DIV] = converter_clock_divide;
			end
			`MCR_ADDR_IDENT_HIGH: begin
				next_rdata = IDENT_CODE[15:8];
			end
			`MCR_ADDR_IDENT_LOW: begin
				next_rdata = IDENT_CODE[7:0];
			end
			`MCR_ADDR_ANALOG: begin
				next_rdata[`MCR_BIT_BATT_LOAD] = battery_load_enable;
				next_rdata[`MCR_BIT_REF_EN]    = converter_reference_enable;
			end
			`MCR_ADDR_BATT_LEVEL: begin
				next_rdata = battery_level_i;
			end
			default: begin
				next_rdata = 8'h00;
			end
		endcase
	end

	// ==============================================
	// read data is registered; it holds between reads
	always @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end
	end

	// ==============================================
	// frame sync comes from the analog side, so three stages
	always @(posedge mclk_i) begin
		if (reset_i) begin
			sync_pipe <= 3'h0;
		end else begin
			sync_pipe <= {sync_pipe[1:0], mux_frame_sync_i};
		end
	end

	assign frame_rise = sync_pipe[1] & ~sync_pipe[2];

	// chop state lives outside the reset-and-wake set only for reset itself
	always @(posedge mclk_i) begin
		if (reset_i) begin
			chop_state <= 1'h0;
		end else if (frame_rise) begin
			case (reference_chop_select)
				`MCR_CHOP_POSITIVE: chop_state <= 1'h0;
				`MCR_CHOP_REVERSED: chop_state <= 1'h1;
				default: begin
					if (!accum_end_i) begin
						chop_state <= ~chop_state;
					end
				end
			endcase
		end
	end

	// ==============================================
	// converter clock; the divider output is already a flop
	mcr_clock_divider u_div (
		.mclk_i      (mclk_i),
		.reset_i     (reset_i),
		.div_eight_i (converter_clock_divide),
		.conv_clk_o  (conv_clk)
	);

	always @(posedge mclk_i) begin
		if (reset_i) begin
			converter_reference_enable_o <= 1'h0;
			battery_load_enable_o        <= 1'h0;
			engine_run_o                 <= 1'h0;
			engine_program_start_o       <= 16'h0000;
			chop_state_o                 <= 1'h0;
			converter_clock_o            <= 1'h0;
			fast_master_clock_o          <= 1'h0;
		end else begin
			converter_reference_enable_o <= converter_reference_enable;
			battery_load_enable_o        <= battery_load_enable;
			engine_run_o                 <= engine_run_enable;
			engine_program_start_o       <= prog_start(engine_program_base);
			chop_state_o                 <= chop_state;
			// gated while the converter is off to save bias and switching
			converter_clock_o            <= conv_clk & converter_reference_enable;
			fast_master_clock_o          <= fast_pll_select_i;
		end
	end
endmodule

// *** sim/mcr_regs_asserts.sv ***
`timescale 1ns/10ps
// ==========================================
// port checks for the config bank
module mcr_regs_asserts #(
	parameter [15:0] IDENT_CODE = 16'h5a3c
) (
	input logic        mclk_i,
	input logic        reset_i,
	input logic        wake_i,
	input logic        fast_pll_select_i,
	input logic [15:0] addr_i,
	input logic        wr_i,
	input logic        rd_i,
	input logic [7:0]  wdata_i,
	input logic [7:0]  rdata_o,
	input logic [7:0]  battery_level_i,
	input logic        converter_reference_enable_o,
	input logic        battery_load_enable_o,
	input logic        engine_run_o,
	input logic [15:0] engine_program_start_o,
	input logic        converter_clock_o,
	input logic        fast_master_clock_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// writes under wake are lost, so they never start a check
	wire wok = wr_i && !wake_i;
	a_run_follows_write: assert property (wok && addr_i == 16'h2106 |-> ##2 engine_run_o == $past(wdata_i[0], 2))
		else $error("engine run bit not applied");
	a_base_scaled: assert property (wok && addr_i == 16'h2109 |-> ##2 engine_program_start_o == {$past(wdata_i[5:0], 2), 10'h000})
		else $error("program start not base times 1024");
	a_analog_bits: assert property (wok && addr_i == 16'h2704 |-> ##2 {converter_reference_enable_o, battery_load_enable_o} == $past(wdata_i[4:3], 2))
		else $error("analog enables not applied");
	a_ident_bytes: assert property (rd_i && addr_i[15:1] == 15'h1180 |=> rdata_o == ($past(addr_i[0]) ? IDENT_CODE[7:0] : IDENT_CODE[15:8]))
		else $error("identification byte wrong");
	a_level_live: assert property (rd_i && addr_i == 16'h2885 |=> rdata_o == $past(battery_level_i))
		else $error("battery level read wrong");
	a_unmapped_zero: assert property (rd_i && addr_i == 16'h2201 |=> rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_clock_gated: assert property (!converter_reference_enable_o [*4] |-> !converter_clock_o)
		else $error("converter clock runs while disabled");
	a_wake_values: assert property (wake_i [*3] |-> engine_program_start_o == 16'h7c00 && !engine_run_o && !converter_reference_enable_o)
		else $error("wake values not applied");
	a_fast_mirror: assert property ($stable(fast_pll_select_i) [*3] |-> fast_master_clock_o == fast_pll_select_i)
		else $error("fast clock select not mirrored");
	c_wake: cover property (wake_i [*3]);
	c_ident: cover property (rd_i && addr_i == 16'h2301);
	c_run: cover property (engine_run_o && converter_clock_o);
endmodule

bind mcr_config_regs mcr_regs_asserts #(.IDENT_CODE(IDENT_CODE)) u_chk (.mclk_i, .reset_i, .wake_i, .fast_pll_select_i,
	.addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o, .battery_level_i, .converter_reference_enable_o,
	.battery_load_enable_o, .engine_run_o, .engine_program_start_o, .converter_clock_o, .fast_master_clock_o);

// *** sim/test_metering_config_io_regs.sv ***
`timescale 1ns/10ps
module test_metering_config_io_regs;
	localparam [15:0] ID = 16'h5a3c; // arbitrary value
	logic        mclk_i = 0, reset_i = 1, wake_i = 0, fast_i = 0, wr_i = 0, rd_i = 0, sync_i = 0, acc_i = 0;
	logic [15:0] addr_i = 16'h0000;
	logic [7:0]  wdata_i = 8'h00, lvl_i = 8'ha7;
	wire  [7:0]  rdata_o;
	wire         ref_o, load_o, run_o, chop_o, cclk_o, fast_o;
	wire  [15:0] start_o;
	int          n_fail = 0, comparisons = 0, cyc = 0;
	mcr_config_regs #(.IDENT_CODE(ID)) uut (.mclk_i, .reset_i, .wake_i, .fast_pll_select_i(fast_i), .addr_i, .wr_i,
		.rd_i, .wdata_i, .rdata_o, .battery_level_i(lvl_i), .mux_frame_sync_i(sync_i), .accum_end_i(acc_i),
		.converter_reference_enable_o(ref_o), .battery_load_enable_o(load_o), .engine_run_o(run_o),
		.engine_program_start_o(start_o), .chop_state_o(chop_o), .converter_clock_o(cclk_o), .fast_master_clock_o(fast_o));
	initial forever #2.5 mclk_i = ~mclk_i;
	// ==========================================
	// shared tasks
	task chk(input logic [15:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// returns once the mirrored outputs have landed
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		#1;
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1 chk(rdata_o, e);
	endtask
	task sync(input logic acc, input logic e);
		@(posedge mclk_i);
		sync_i <= 1'b1;
		acc_i <= acc;
		repeat (8) @(posedge mclk_i);
		sync_i <= 1'b0;
		acc_i <= 1'b0;
		repeat (4) @(posedge mclk_i);
		#1 chk(chop_o, e);
	endtask
	// a 64 cycle window is a whole number of periods, so phase does not matter
	task cnt(input int e);
		int n;
		logic last;
		n = 0;
		last = cclk_o;
		repeat (16) @(posedge mclk_i);
		repeat (64) begin
			@(posedge mclk_i);
			#1 if (cclk_o === 1'b1 && last === 1'b0) n++;
			last = cclk_o;
		end
		chk(16'(n), 16'(e));
	endtask
	// ==========================================
	// scenarios
	task t_rw;
		rd(16'h2106, 8'h00);
		rd(16'h2109, 8'h1f);
		chk(start_o, 16'h7c00);
		wr(16'h2106, 8'hff);
		chk(run_o, 1'b1);
		rd(16'h2106, 8'h0d);
		wr(16'h2109, 8'h05);
		chk(start_o, 16'h1400);
		wr(16'h2704, 8'hff);
		chk({ref_o, load_o}, 2'h3);
		rd(16'h2704, 8'h18);
		wr(16'h2704, 8'h00);
		chk({ref_o, load_o}, 2'h0);
		wr(16'h2106, 8'h00);
		chk(run_o, 1'b0);
	endtask
	task t_ro;
		wr(16'h2300, 8'hff);
		rd(16'h2300, ID[15:8]);
		rd(16'h2301, ID[7:0]);
		wr(16'h2885, 8'h00);
		rd(16'h2885, 8'ha7);
		@(posedge mclk_i);
		lvl_i <= 8'h3e;
		rd(16'h2885, 8'h3e);
		rd(16'h2201, 8'h00);
	endtask
	task t_div;
		wr(16'h2704, 8'h10);
		cnt(16);
		wr(16'h2200, 8'hff);
		rd(16'h2200, 8'h20);
		cnt(8);
		wr(16'h2704, 8'h00);
		cnt(0);
	endtask
	task t_chop;
		wr(16'h2106, 8'h08);
		sync(1'b0, 1'b1);
		wr(16'h2106, 8'h04);
		sync(1'b0, 1'b0);
		wr(16'h2106, 8'h00);
		sync(1'b0, 1'b1);
		sync(1'b1, 1'b1);
		wr(16'h2106, 8'h0c);
		sync(1'b0, 1'b0);
	endtask
	task t_wake;
		@(posedge mclk_i);
		fast_i <= 1'b1;
		wr(16'h2109, 8'h05);
		@(posedge mclk_i);
		wake_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		wake_i <= 1'b0;
		rd(16'h2109, 8'h1f);
		rd(16'h2200, 8'h00);
		rd(16'h2885, 8'h3e);
		chk(fast_o, 1'b1);
	endtask
	task wrap_up;
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// the whole run needs well under 2000 cycles
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			wrap_up;
		end
	end
	initial begin
		repeat (10) @(posedge mclk_i);
		reset_i <= 1'b0;
		// the engine is enabled before the program base is loaded, and the converter before the clock divide bit is written
		t_rw;
		t_ro;
		t_div;
		t_chop;
		t_wake;
		wrap_up;
	end
endmodule
